// [hw/ufl_top.sv]
// FIFO level interrupts and receiver automatic flow control with APB slave
// Functional notes
// [R1] Large FIFO rx levels: 1,128,192,256 held
// [R2] Small FIFO tx levels: 8,4,6,1 empty
// [R3] Large FIFO tx levels: 256,128,192,1 empty
// [R4] Receiver mode reachable directly and via pointer
// [R5] Auto flow negates on start at 240+
// [R6] Reassert once fill drops below 240
// [R7] Small FIFO negates at full, position 8
// [R8] Software drives line via command/port bits
// [R9] Software avoids mixing hardware and in-band flow
// [R10] Remote transmitter stops on inactive permit
// [R11] Depth bit: 0 selects 8, 1 selects 256
// [R12] Small FIFO rx levels: 1,3,6,8 held
// [R13] FIFO requests follow their condition only

`timescale 1ns/1ps
module ufl_top (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // UART datapath status (same clock domain)
    input  wire logic [8:0]  rx_fill_count,
    input  wire logic [8:0]  tx_fill_count,
    input  wire logic        rx_start_bit,
    // FIFO level requests and interrupt
    output logic             rx_has_data,
    output logic             tx_has_space,
    output logic             irq,
    // Request-to-send on port pin two, active low
    output logic             flow_hold_out_n
);
    // Software-visible registers
    logic [7:0]  fifo_mode_control_q;
    logic [7:0]  receiver_mode_control_q;
    logic [7:0]  output_port_q;
    logic [1:0]  mr_ptr_q;
    logic [2:0]  irq_status_q;
    logic [2:0]  irq_mask_q;
    logic        rts_cmd_q;

    // Flow hold and its delayed copy
    logic        auto_hold_q;
    logic        hold_q;

    // Level results and registered requests
    logic        rx_hit;
    logic        tx_hit;
    logic        rx_has_data_q;
    logic        tx_has_space_q;
    logic        irq_q;

    // Bus response
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // Decoded fields and fill arithmetic
    logic        fifo_depth_select;
    logic [1:0]  level_sel;
    logic        rx_auto_flow_enable;
    logic [8:0]  depth;
    logic [8:0]  tx_empty;
    logic        flow_full;

    // Bus strobes and interrupt events
    logic        wr_go;
    logic        rd_go;
    logic [2:0]  irq_event;

    // Decodes whether an address is mapped; other addresses get an error response
    // Writes anywhere else are dropped
    function automatic logic addr_mapped(input logic [11:0] a);
        case (a)
            ufl_pkg::ADDR_MR_POINTER, ufl_pkg::ADDR_RX_MODE,
            ufl_pkg::ADDR_FIFO_MODE,  ufl_pkg::ADDR_RX_LEVEL,
            ufl_pkg::ADDR_TX_LEVEL,   ufl_pkg::ADDR_COMMAND,
            ufl_pkg::ADDR_OUT_PORT,   ufl_pkg::ADDR_IRQ_STATUS,
            ufl_pkg::ADDR_IRQ_MASK,   ufl_pkg::ADDR_LINE_STATE:
                addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // Configuration fields
    assign fifo_depth_select   = fifo_mode_control_q[ufl_pkg::FIFO_DEPTH_BIT];
    assign level_sel = {fifo_mode_control_q[ufl_pkg::LEVEL_HIGH_BIT],
                        receiver_mode_control_q[ufl_pkg::LEVEL_LOW_BIT]};
    assign rx_auto_flow_enable = receiver_mode_control_q[ufl_pkg::AUTO_FLOW_BIT];
    assign depth = fifo_depth_select ? ufl_pkg::DEPTH_LARGE
                                     : ufl_pkg::DEPTH_SMALL; // [R11]
    // Wraps if a count ever exceeds the depth
    assign tx_empty = depth - tx_fill_count;
    // Small FIFO uses full (8), large uses 240
    assign flow_full = fifo_depth_select
                     ? (rx_fill_count >= ufl_pkg::FLOW_THRESHOLD)
                     : (rx_fill_count >= ufl_pkg::DEPTH_SMALL); // [R5] [R7]

    // APB access phase; one registered answer in the cycle after the access cycle
    // pready_q blocks a second take
    assign wr_go = psel && penable && pwrite && !pready_q;
    assign rd_go = psel && penable && !pwrite && !pready_q;

    // Level comparators for receive and transmit FIFOs
    // is_tx selects the empty-count table
    ufl_level_cmp u_rx_cmp (
        .depth_large (fifo_depth_select),
        .level_sel   (level_sel),
        .is_tx       (1'b0),
        .amount      (rx_fill_count),
        .hit         (rx_hit)
    );

    ufl_level_cmp u_tx_cmp (
        .depth_large (fifo_depth_select),
        .level_sel   (level_sel),
        .is_tx       (1'b1),
        .amount      (tx_empty),
        .hit         (tx_hit)
    );

    // Mode registers, direct and through the legacy pointer
    // The pointer parks at two, where writes fall through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_mode_control_q     <= ufl_pkg::FIFO_MODE_RESET;
            receiver_mode_control_q <= ufl_pkg::RX_MODE_RESET;
            mr_ptr_q                <= ufl_pkg::PTR_RESET;
        end else if (wr_go) begin
            case (paddr)
                ufl_pkg::ADDR_FIFO_MODE:
                    fifo_mode_control_q <= pwdata[7:0];
                ufl_pkg::ADDR_RX_MODE:
                    receiver_mode_control_q <= pwdata[7:0]; // [R4]
                ufl_pkg::ADDR_MR_POINTER: begin
                    // Pointer 0 hits FIFO mode, 1 the receiver mode
                    if (mr_ptr_q == 2'h0) begin
                        fifo_mode_control_q <= pwdata[7:0];
                    end else if (mr_ptr_q == 2'h1) begin
                        receiver_mode_control_q <= pwdata[7:0]; // [R4]
                    end
                    if (mr_ptr_q != 2'h2) begin
                        mr_ptr_q <= mr_ptr_q + 2'h1;
                    end
                end
                ufl_pkg::ADDR_COMMAND: begin
                    if (pwdata[3:2] == 2'h1) begin
                        mr_ptr_q <= 2'h0; // Pointer reset command
                    end
                end
                default: ;
            endcase
        end
    end

    // Output port and command driven software request-to-send
    // Assert wins when both command bits are set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_port_q <= ufl_pkg::OUT_PORT_RESET;
            rts_cmd_q     <= 1'b0;
        end else if (wr_go && paddr == ufl_pkg::ADDR_OUT_PORT) begin
            output_port_q <= pwdata[7:0]; // [R8]
        end else if (wr_go && paddr == ufl_pkg::ADDR_COMMAND) begin
            if (pwdata[ufl_pkg::CMD_RTS_ASSERT]) begin
                output_port_q[ufl_pkg::OUT_PORT_RTS_BIT] <= 1'b1; // [R8]
            end else if (pwdata[ufl_pkg::CMD_RTS_NEGATE]) begin
                output_port_q[ufl_pkg::OUT_PORT_RTS_BIT] <= 1'b0; // [R8]
            end
            rts_cmd_q <= pwdata[ufl_pkg::CMD_RTS_ASSERT];
        end
    end

    // Automatic hold: set on start bit when near full, clear below level
    // Both negation and reassertion are automatic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_hold_q <= 1'b0;
        end else if (!rx_auto_flow_enable) begin
            auto_hold_q <= 1'b0; // [R5]
        end else if (rx_start_bit && flow_full) begin
            auto_hold_q <= 1'b1; // [R5] [R7]
        end else if (!flow_full) begin
            auto_hold_q <= 1'b0; // [R6]
        end
    end

    // Line output: low when software asserts and no automatic hold
    // Registered so the pin never glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_hold_out_n <= 1'b1;
            hold_q          <= 1'b0;
        end else begin
            flow_hold_out_n <= !(output_port_q[ufl_pkg::OUT_PORT_RTS_BIT]
                                 && !auto_hold_q); // [R8] [R10]
            hold_q          <= auto_hold_q;
        end
    end

    // Level requests follow their condition every cycle
    // They trail the fill counts by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_has_data_q  <= 1'b0;
            tx_has_space_q <= 1'b0;
        end else begin
            rx_has_data_q  <= rx_hit; // [R13]
            tx_has_space_q <= tx_hit; // [R13]
        end
    end

    // Rising edges of the requests and of automatic hold are events
    // Delayed copies reset low, so a condition already true out of reset raises an event
    assign irq_event = {auto_hold_q & ~hold_q,
                        tx_hit & ~tx_has_space_q,
                        rx_hit & ~rx_has_data_q};

    // Sticky status, write one to clear, set wins over clear
    // Mask writes never touch status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= 3'h0;
            irq_mask_q   <= 3'h0;
        end else begin
            if (wr_go && paddr == ufl_pkg::ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
            if (wr_go && paddr == ufl_pkg::ADDR_IRQ_STATUS) begin
                irq_status_q <= (irq_status_q & ~pwdata[2:0]) | irq_event;
            end else begin
                irq_status_q <= irq_status_q | irq_event;
            end
        end
    end

    // Interrupt level
    // Masked events stay visible in status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // APB read data and completion
    // Read data is zero outside the answer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_mapped(paddr);
            prdata_q  <= 32'h0000_0000;
            if (rd_go) begin
                case (paddr)
                    ufl_pkg::ADDR_MR_POINTER: begin
                        if (mr_ptr_q == 2'h0) begin
                            prdata_q[7:0] <= fifo_mode_control_q;
                        end else if (mr_ptr_q == 2'h1) begin
                            prdata_q[7:0] <= receiver_mode_control_q;
                        end
                    end
                    ufl_pkg::ADDR_RX_MODE:
                        prdata_q[7:0] <= receiver_mode_control_q; // [R4]
                    ufl_pkg::ADDR_FIFO_MODE:
                        prdata_q[7:0] <= fifo_mode_control_q;
                    ufl_pkg::ADDR_RX_LEVEL:
                        prdata_q[8:0] <= rx_fill_count;
                    ufl_pkg::ADDR_TX_LEVEL:
                        prdata_q[8:0] <= tx_fill_count;
                    ufl_pkg::ADDR_OUT_PORT:
                        prdata_q[7:0] <= output_port_q;
                    ufl_pkg::ADDR_IRQ_STATUS:
                        prdata_q[2:0] <= irq_status_q;
                    ufl_pkg::ADDR_IRQ_MASK:
                        prdata_q[2:0] <= irq_mask_q;
                    ufl_pkg::ADDR_LINE_STATE:
                        prdata_q[3:0] <= {rts_cmd_q, auto_hold_q,
                                          tx_has_space_q, rx_has_data_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Ports straight from their flip-flops
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign rx_has_data  = rx_has_data_q;
    assign tx_has_space = tx_has_space_q;
    assign irq          = irq_q;
endmodule

// [hw/ufl_pkg.sv]
// Package: register map, field positions and thresholds for the FIFO level block
package ufl_pkg;
    // Register byte addresses (printed offsets 0x00 and 0x21 are indices)
    localparam logic [7:0]  IDX_MR_POINTER   = 8'h00;
    localparam logic [7:0]  IDX_RX_MODE      = 8'h21;
    localparam logic [11:0] ADDR_MR_POINTER  = 12'h000;
    localparam logic [11:0] ADDR_RX_MODE     = 12'h084;
    localparam logic [11:0] ADDR_FIFO_MODE   = 12'h100;
    localparam logic [11:0] ADDR_RX_LEVEL    = 12'h104;
    localparam logic [11:0] ADDR_TX_LEVEL    = 12'h108;
    localparam logic [11:0] ADDR_COMMAND     = 12'h10C;
    localparam logic [11:0] ADDR_OUT_PORT    = 12'h110;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h114;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'h118;
    localparam logic [11:0] ADDR_LINE_STATE  = 12'h11C;
    // Field positions
    localparam int FIFO_DEPTH_BIT    = 3;
    localparam int LEVEL_HIGH_BIT    = 6;
    localparam int LEVEL_LOW_BIT     = 6;
    localparam int AUTO_FLOW_BIT     = 7;
    localparam int OUT_PORT_RTS_BIT  = 2;
    localparam int CMD_RTS_ASSERT    = 0;
    localparam int CMD_RTS_NEGATE    = 1;
    // Reset values
    localparam logic [7:0] FIFO_MODE_RESET = 8'h00;
    localparam logic [7:0] RX_MODE_RESET   = 8'h00;
    localparam logic [7:0] OUT_PORT_RESET  = 8'h00;
    localparam logic [1:0] PTR_RESET       = 2'h0;
    // Counts and thresholds
    localparam logic [8:0] DEPTH_SMALL     = 9'h008;
    localparam logic [8:0] DEPTH_LARGE     = 9'h100;
    localparam logic [8:0] RX_SMALL_LV1    = 9'h003;
    localparam logic [8:0] RX_SMALL_LV2    = 9'h006;
    localparam logic [8:0] TX_SMALL_LV1    = 9'h004;
    localparam logic [8:0] TX_SMALL_LV2    = 9'h006;
    localparam logic [8:0] LARGE_LV1       = 9'h080;
    localparam logic [8:0] LARGE_LV2       = 9'h0C0;
    localparam logic [8:0] ONE_ENTRY       = 9'h001;
    localparam logic [8:0] FLOW_THRESHOLD  = 9'h0F0;
    // Interrupt status bit positions
    localparam int IRQ_RX_LEVEL = 0;
    localparam int IRQ_TX_LEVEL = 1;
    localparam int IRQ_FLOW_HOLD = 2;
    localparam int IRQ_WIDTH    = 3;
endpackage

// [hw/ufl_level_cmp.sv]
// Fill-level comparator: picks a FIFO interrupt threshold from the mode bits
`timescale 1ns/1ps
module ufl_level_cmp (
    // Configuration
    input  wire logic       depth_large,
    input  wire logic [1:0] level_sel,
    input  wire logic       is_tx,
    // Occupancy of the FIFO (entries held, or entries empty for tx)
    input  wire logic [8:0] amount,
    // Result
    output logic            hit
);
    logic [8:0] thresh;

    // Threshold table for both depths and directions
    always_comb begin
        thresh = ufl_pkg::ONE_ENTRY;
        case (level_sel)
            2'h0: begin
                if (is_tx) begin
                    thresh = depth_large ? ufl_pkg::DEPTH_LARGE
                                         : ufl_pkg::DEPTH_SMALL; // [R2] [R3]
                end else begin
                    thresh = ufl_pkg::ONE_ENTRY; // [R1] [R12]
                end
            end
            2'h1: begin
                if (depth_large) begin
                    thresh = ufl_pkg::LARGE_LV1; // [R1] [R3]
                end else begin
                    thresh = is_tx ? ufl_pkg::TX_SMALL_LV1
                                   : ufl_pkg::RX_SMALL_LV1; // [R2] [R12]
                end
            end
            2'h2: begin
                if (depth_large) begin
                    thresh = ufl_pkg::LARGE_LV2; // [R1] [R3]
                end else begin
                    thresh = is_tx ? ufl_pkg::TX_SMALL_LV2
                                   : ufl_pkg::RX_SMALL_LV2; // [R2] [R12]
                end
            end
            2'h3: begin
                if (is_tx) begin
                    thresh = ufl_pkg::ONE_ENTRY; // [R2] [R3]
                end else begin
                    thresh = depth_large ? ufl_pkg::DEPTH_LARGE
                                         : ufl_pkg::DEPTH_SMALL; // [R1] [R12]
                end
            end
            default: thresh = ufl_pkg::ONE_ENTRY;
        endcase
    end

    // Condition holds only while the amount reaches the threshold
    assign hit = (amount >= thresh); // [R13]
endmodule

// [verif/ufl_chk.sv]
// Checker for level requests, flow hold and APB timing
`timescale 1ns/1ps
module ufl_chk (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Datapath and outputs
    input wire logic [8:0]  rx_fill_count,
    input wire logic [8:0]  tx_fill_count,
    input wire logic        rx_start_bit,
    input wire logic        rx_has_data,
    input wire logic        tx_has_space,
    input wire logic        flow_hold_out_n
);
    logic       dep_q, hi_q, lo_q, af_q, pb_q;
    logic       erx_q, etx_q, wr, sw, map;
    logic [1:0] ptr_q;
    logic [8:0] thr, emp;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Threshold picked by depth, level code and direction
    function automatic logic lvl(logic d, logic [1:0] s, logic [8:0] n,
                                 logic t);
        logic [8:0] m;
        case (s)
            2'h0: m = t ? (d ? 9'h100 : 9'h008) : 9'h001;
            2'h1: m = d ? 9'h080 : (t ? 9'h004 : 9'h003);
            2'h2: m = d ? 9'h0C0 : 9'h006;
            default: m = t ? 9'h001 : (d ? 9'h100 : 9'h008);
        endcase
        return n >= m;
    endfunction
    // Accepted write, software request, hold threshold, empty count
    assign wr  = psel && penable && !pready && pwrite;
    assign sw  = pb_q;
    assign thr = dep_q ? 9'h0F0 : 9'h008;
    assign emp = (dep_q ? 9'h100 : 9'h008) - tx_fill_count;
    assign map = paddr == 12'h000 || paddr == 12'h084 ||
                 (paddr >= 12'h100 && paddr <= 12'h11C);
    // Shadow of the mode, pointer and software request state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dep_q, hi_q, lo_q, af_q, pb_q, ptr_q} <= '0;
        end else if (wr) begin
            case (paddr)
                12'h000: begin
                    if (ptr_q == 2'h0) {hi_q, dep_q} <= {pwdata[6], pwdata[3]};
                    if (ptr_q == 2'h1) {af_q, lo_q} <= pwdata[7:6];
                    if (ptr_q != 2'h2) ptr_q <= ptr_q + 2'h1;
                end
                12'h084: {af_q, lo_q} <= pwdata[7:6];
                12'h100: {hi_q, dep_q} <= {pwdata[6], pwdata[3]};
                12'h10C: begin
                    if (pwdata[3:2] == 2'h1) ptr_q <= 2'h0;
                    if (pwdata[0] || pwdata[1]) pb_q <= pwdata[0];
                end
                12'h110: pb_q <= pwdata[2];
                default: ;
            endcase
        end
    end
    // Expected level requests, one cycle behind the counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erx_q <= 1'b0;
            etx_q <= 1'b0;
        end else begin
            erx_q <= lvl(dep_q, {hi_q, lo_q}, rx_fill_count, 1'b0);
            etx_q <= lvl(dep_q, {hi_q, lo_q}, emp, 1'b1);
        end
    end
    rx_level_a: assert property (rx_has_data == erx_q)
        else $error("rx level request differs");
    tx_level_a: assert property (tx_has_space == etx_q)
        else $error("tx level request differs");
    hold_set_a: assert property (
        af_q && rx_start_bit && rx_fill_count >= thr ##1
        rx_fill_count >= thr |=> flow_hold_out_n)
        else $error("flow hold not raised");
    hold_free_a: assert property (
        (af_q && sw && rx_fill_count < thr) [*2] |=> !flow_hold_out_n)
        else $error("flow hold not released");
    sw_drive_a: assert property (
        (!af_q && rx_fill_count < thr) [*2] |=> flow_hold_out_n == !$past(sw))
        else $error("software request not on line");
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    unmapped_a: assert property (
        pready && paddr[1:0] == 2'h0 |-> pslverr == !map)
        else $error("error response wrong");
endmodule
bind ufl_top ufl_chk ufl_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .rx_fill_count(rx_fill_count),
    .tx_fill_count(tx_fill_count), .rx_start_bit(rx_start_bit),
    .rx_has_data(rx_has_data), .tx_has_space(tx_has_space),
    .flow_hold_out_n(flow_hold_out_n)
);

// [verif/ufl_remote_tx.sv]
// Remote transmitter model: sends start bits only while permitted
`timescale 1ns/1ps
module ufl_remote_tx (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Send request and permit line
    input  wire logic send,
    input  wire logic flow_hold_out_n,
    // Start strobe and count of characters sent
    output logic       rx_start_bit,
    output logic [7:0] sent
);
    logic [1:0] gap_q;
    // One character every four cycles, none while held off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q        <= 2'h0;
            rx_start_bit <= 1'b0;
            sent         <= 8'h00;
        end else begin
            gap_q        <= gap_q + 2'h1;
            rx_start_bit <= send && !flow_hold_out_n && gap_q == 2'h0;
            sent         <= sent + {7'h00, rx_start_bit};
        end
    end
endmodule

// [verif/ufl_top_tb.sv]
// Testbench for the FIFO level and flow control block
`timescale 1ns/1ps
module ufl_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        start, rxd, txs, irq, hold_n, send, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  rxf, txf;
    logic [7:0]  sent;
    int          errors, compares;
    // Design and remote transmitter
    ufl_top ufl_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_fill_count(rxf),
        .tx_fill_count(txf), .rx_start_bit(start), .rx_has_data(rxd),
        .tx_has_space(txs), .irq(irq), .flow_hold_out_n(hold_n)
    );
    ufl_remote_tx ufl_remote_tx_i (
        .pclk(pclk), .presetn(presetn), .send(send),
        .flow_hold_out_n(hold_n), .rx_start_bit(start), .sent(sent)
    );
    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Verdict and end of run
    task automatic complete_run;
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One comparison
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                complete_run();
            end
            @(posedge pclk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [11:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // Set fill counts and wait for the registered levels
    task automatic setf(input logic [8:0] r, t);
        @(posedge pclk);
        rxf <= r;
        txf <= t;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic tick;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    // Bounded wait for the flow line to reach a level
    task automatic wait_hold(input logic e);
        for (int n = 0; hold_n !== e; n++) begin
            if (n > 40) begin
                errors++;
                complete_run();
            end
            @(negedge pclk);
        end
    endtask
    // Reset values and an unmapped access
    task automatic t_reset;
        chk("flow_hold_out_n", 32'h1, 32'(hold_n));
        rdc("rx_mode", 12'h084, 32'h0);
        rdc("fifo_mode", 12'h100, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
    endtask
    // Direct and pointer access to the receiver mode register
    task automatic t_ptr;
        wr(12'h084, 32'h40);
        wr(12'h10C, 32'h4);
        wr(12'h000, 32'h08);
        rdc("ptr rx_mode", 12'h000, 32'h40);
        rdc("fifo_mode", 12'h100, 32'h08);
        wr(12'h000, 32'h0);
        rdc("rx_mode", 12'h084, 32'h0);
        rdc("ptr end", 12'h000, 32'h0);
    endtask
    // Every depth and level code, at and just below each threshold
    task automatic t_levels;
        int rt[2][4] = '{'{1, 3, 6, 8}, '{1, 128, 192, 256}};
        int tt[2][4] = '{'{8, 4, 6, 1}, '{256, 128, 192, 1}};
        int dp;
        for (int d = 0; d < 2; d++) begin
            dp = d ? 256 : 8;
            for (int s = 0; s < 4; s++) begin
                wr(12'h100, {25'h0, s[1], 2'h0, d[0], 3'h0});
                wr(12'h084, {24'h0, 1'b0, s[0], 6'h0});
                setf(9'(rt[d][s]), 9'(dp - tt[d][s]));
                chk("rx_has_data", 32'h1, 32'(rxd));
                chk("tx_has_space", 32'h1, 32'(txs));
                setf(9'(rt[d][s] - 1), 9'(dp - tt[d][s] + 1));
                chk("rx_has_data", 32'h0, 32'(rxd));
                chk("tx_has_space", 32'h0, 32'(txs));
            end
        end
    endtask
    // Interrupt raised while masked, unmasked, then cleared
    task automatic t_irq;
        setf(9'h0, 9'h1);
        wr(12'h100, 32'h0);
        wr(12'h084, 32'h0);
        wr(12'h114, 32'h7);
        wr(12'h118, 32'h0);
        setf(9'h1, 9'h1);
        chk("irq masked", 32'h0, 32'(irq));
        rdc("irq_status", 12'h114, 32'h1);
        rdc("rx_level", 12'h104, 32'h1);
        rdc("line_state", 12'h11C, 32'h1);
        wr(12'h118, 32'h1);
        tick;
        chk("irq", 32'h1, 32'(irq));
        wr(12'h114, 32'h1);
        tick;
        chk("irq cleared", 32'h0, 32'(irq));
    endtask
    // Software drives the line by command and by port bit
    task automatic t_sw;
        wr(12'h10C, 32'h1);
        tick;
        chk("cmd assert", 32'h0, 32'(hold_n));
        wr(12'h10C, 32'h2);
        tick;
        chk("cmd negate", 32'h1, 32'(hold_n));
        wr(12'h110, 32'h4);
        tick;
        chk("port assert", 32'h0, 32'(hold_n));
    endtask
    // Automatic hold in both depths, remote sender stalls
    task automatic t_flow;
        logic [7:0] n;
        wr(12'h100, 32'h08);
        wr(12'h084, 32'h80);
        setf(9'h0F0, 9'h0);
        @(posedge pclk);
        send <= 1'b1;
        wait_hold(1'b1);
        n = sent;
        repeat (12) tick;
        chk("sender stalled", 32'(n), 32'(sent));
        setf(9'h0EF, 9'h0);
        wait_hold(1'b0);
        setf(9'h007, 9'h0);
        wr(12'h100, 32'h0);
        repeat (12) tick;
        chk("below full", 32'h0, 32'(hold_n));
        setf(9'h008, 9'h0);
        wait_hold(1'b1);
        setf(9'h007, 9'h0);
        wait_hold(1'b0);
        @(posedge pclk);
        send <= 1'b0;
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, send} = 4'h0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        rxf      = 9'h0;
        txf      = 9'h0;
        errors   = 0;
        compares = 0;
        presetn  = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_ptr;
        t_levels;
        t_irq;
        t_sw;
        t_flow;
        complete_run;
    end
endmodule
